// ==== design/mtc_pin_edge.sv ====
// pin synchroniser with falling-edge detector
`timescale 1ns/1ps
`default_nettype none
module mtc_pin_edge import mtc_pkg::*; #(
	parameter int W = PIN_CNT
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out,
	output logic      [W-1:0] fall_out
);

	logic [W-1:0] sync1_r;
	logic [W-1:0] sync2_r;
	logic [W-1:0] prev_r;
	logic [W-1:0] sync1_nxt;
	logic [W-1:0] sync2_nxt;
	logic [W-1:0] prev_nxt;

	always_comb begin
		sync1_nxt = pin_in;
		sync2_nxt = sync1_r;
		prev_nxt  = sync2_r;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r  <= '0;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			prev_r  <= prev_nxt;
		end
	end

	assign level_out = sync2_r;
	// RULE_21: one pulse per edge
	assign fall_out  = prev_r & ~sync2_r;

	fall_once_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE_21
		(fall_out != '0) |=> ((fall_out & $past(fall_out)) == '0))
		else $error("edge pulse lasted two cycles");

endmodule
`default_nettype wire

// ==== design/mtc_timer_counters.sv ====
// timers 0, 1 and 2 with their special function registers
//
// Summary of operation
// RULE_01: mode 0 is 13-bit, overflow sets flag
// RULE_02: 13 bits: high byte plus low five bits
// RULE_03: count only when run and gate allow
// RULE_04: starting a timer keeps its count
// RULE_05: timer function counts every core cycle
// RULE_06: mode 1 uses all sixteen bits
// RULE_07: mode 2 reloads low from high byte
// RULE_08: timer 1 in mode 3 holds count
// RULE_09: split low byte uses timer 0 controls
// RULE_10: split high byte uses timer 1 run/flag
// RULE_11: timer 1 runs for baud without flag
// RULE_12: timer 2 mode from run, clocks, capture
// RULE_13: timer 2 rollover reloads and sets flag
// RULE_14: trigger fall reloads, sets external flag
// RULE_15: capture mode overflow sets flag bit 7
// RULE_16: trigger fall captures count, sets bit 6
// RULE_17: baud mode never sets overflow flag
// RULE_18: baud mode trigger still sets external flag
// RULE_19: flags set by hardware, cleared by software
// RULE_20: count select; baud forces autoreload
// RULE_21: pins synchronised, one event per edge
`timescale 1ns/1ps
`default_nettype none
module mtc_timer_counters import mtc_pkg::*; (
	// clock and reset
	input  wire logic         CLK_IN,
	input  wire logic         RESET_IN,
	// special function register access
	input  wire mtc_sfr_req_t SFR_REQ_IN,
	output logic      [7:0]   SFR_RDATA_OUT,
	// pins
	input  wire logic         EXT_IRQ0_PIN_IN,
	input  wire logic         EXT_IRQ1_PIN_IN,
	input  wire logic         T0_COUNT_PIN_IN,
	input  wire logic         T1_COUNT_PIN_IN,
	input  wire logic         T2_COUNT_PIN_IN,
	input  wire logic         T2_TRIGGER_INPUT_IN,
	// flags and overflow ticks
	output logic              T0_OVERFLOW_FLAG_OUT,
	output logic              T1_OVERFLOW_FLAG_OUT,
	output logic              T2_OVERFLOW_FLAG_OUT,
	output logic              T2_EXTERNAL_FLAG_OUT,
	output logic              T1_OVF_TICK_OUT,
	output logic              T2_BAUD_TICK_OUT
);

	////////////////////////////////////////////////////////////////////////
	logic [PIN_CNT-1:0] pin_level;
	logic [PIN_CNT-1:0] pin_fall;

	// RULE_21: all pins pass the synchroniser
	mtc_pin_edge #(.W(PIN_CNT)) u_pins (
		.clk_in    (CLK_IN),
		.rst_in    (RESET_IN),
		.pin_in    ({T2_TRIGGER_INPUT_IN, T2_COUNT_PIN_IN, T1_COUNT_PIN_IN,
		             T0_COUNT_PIN_IN, EXT_IRQ1_PIN_IN, EXT_IRQ0_PIN_IN}),
		.level_out (pin_level),
		.fall_out  (pin_fall)
	);

	logic w_ctl, w_mod, w_lo0, w_hi0, w_lo1, w_hi1;
	logic w_ctl2, w_rcl, w_rch, w_lo2, w_hi2;
	logic [7:0] wd;

	always_comb begin
		wd      = SFR_REQ_IN.wdata;
		w_ctl   = SFR_REQ_IN.wr && SFR_REQ_IN.addr == ADDR_CTL01;
		w_mod   = SFR_REQ_IN.wr && SFR_REQ_IN.addr == ADDR_MOD01;
		w_lo0   = SFR_REQ_IN.wr && SFR_REQ_IN.addr == ADDR_LO0;
		w_hi0   = SFR_REQ_IN.wr && SFR_REQ_IN.addr == ADDR_HI0;
		w_lo1   = SFR_REQ_IN.wr && SFR_REQ_IN.addr == ADDR_LO1;
		w_hi1   = SFR_REQ_IN.wr && SFR_REQ_IN.addr == ADDR_HI1;
		w_ctl2  = SFR_REQ_IN.wr && SFR_REQ_IN.addr == ADDR_CTL2;
		w_rcl   = SFR_REQ_IN.wr && SFR_REQ_IN.addr == ADDR_RCAPL;
		w_rch   = SFR_REQ_IN.wr && SFR_REQ_IN.addr == ADDR_RCAPH;
		w_lo2   = SFR_REQ_IN.wr && SFR_REQ_IN.addr == ADDR_LO2;
		w_hi2   = SFR_REQ_IN.wr && SFR_REQ_IN.addr == ADDR_HI2;
	end

	// one count step of timer 0 or 1 in the given mode
	function automatic mtc_cnt_t count_step(input logic [1:0] mode, input logic [7:0] hi, input logic [7:0] lo);
		mtc_cnt_t    r;
		logic [13:0] s13;
		logic [16:0] s16;
		logic [8:0]  s8;
		s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
		s16 = {1'b0, hi, lo} + 17'h00001;
		s8  = {1'b0, lo} + 9'h001;
		case (mode)
			// RULE_01 RULE_02: upper low-byte bits are left alone
			MODE_13BIT: r = '{ovf: s13[13], hi: s13[12:5], lo: {lo[7:5], s13[4:0]}};
			// RULE_06: full sixteen bits
			MODE_16BIT: r = s16;
			// RULE_07: reload low byte, high byte untouched
			MODE_AUTO8: r = (lo == BYTE_ONES) ? '{ovf: 1'b1, hi: hi, lo: hi} : '{ovf: 1'b0, hi: hi, lo: s8[7:0]};
			default:    r = '{ovf: s8[8], hi: hi, lo: s8[7:0]};
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// timers 0 and 1
	logic [7:0] t0_low_byte_r, t0_high_byte_r, t1_low_byte_r, t1_high_byte_r;
	logic [7:0] t0_low_byte_nxt, t0_high_byte_nxt, t1_low_byte_nxt, t1_high_byte_nxt;
	mtc_timer01_mode_reg_t  t0_mode_r, t1_mode_r, t0_mode_nxt, t1_mode_nxt;
	logic       t0_run_bit_r, t1_run_bit_r, t0_overflow_flag_r, t1_overflow_flag_r;
	logic       t0_run_bit_nxt, t1_run_bit_nxt, t0_overflow_flag_nxt, t1_overflow_flag_nxt;
	logic       t1_tick_r, t1_tick_nxt;
	logic       t0_go, t1_go, th0_go, split0;
	logic [8:0] th0_sum;
	mtc_cnt_t   t0_step, t1_step;

	always_comb begin
		split0  = t0_mode_r.mode == MODE_SPLIT;
		// RULE_03 RULE_05 RULE_09: run bit, gate and pin; no prescaler
		t0_go   = t0_run_bit_r & (~t0_mode_r.gate | pin_level[PIN_IRQ0]) & (t0_mode_r.ct ? pin_fall[PIN_T0] : 1'b1);
		// RULE_08 RULE_11: timer 1 mode 3 acts as run bit cleared
		t1_go   = t1_run_bit_r & (~t1_mode_r.gate | pin_level[PIN_IRQ1]) & (t1_mode_r.ct ? pin_fall[PIN_T1] : 1'b1)
		          & (t1_mode_r.mode != MODE_SPLIT);
		// RULE_10: split high byte counts core cycles under timer 1 run bit
		th0_go  = split0 & t1_run_bit_r;
		th0_sum = {1'b0, t0_high_byte_r} + 9'h001;
		t0_step = count_step(t0_mode_r.mode, t0_high_byte_r, t0_low_byte_r);
		t1_step = count_step(t1_mode_r.mode, t1_high_byte_r, t1_low_byte_r);

		t0_low_byte_nxt  = t0_go ? t0_step.lo : t0_low_byte_r;
		t0_high_byte_nxt = split0 ? (th0_go ? th0_sum[7:0] : t0_high_byte_r) : (t0_go ? t0_step.hi : t0_high_byte_r);
		t1_low_byte_nxt  = t1_go ? t1_step.lo : t1_low_byte_r;
		t1_high_byte_nxt = t1_go ? t1_step.hi : t1_high_byte_r;
		// software writes win over a count in the same cycle
		if (w_lo0) t0_low_byte_nxt = wd;
		if (w_hi0) t0_high_byte_nxt = wd;
		if (w_lo1) t1_low_byte_nxt = wd;
		if (w_hi1) t1_high_byte_nxt = wd;

		t0_mode_nxt    = w_mod ? wd[MOD_T0_LSB +: 4] : t0_mode_r;
		t1_mode_nxt    = w_mod ? wd[MOD_T1_LSB +: 4] : t1_mode_r;
		// RULE_04: run bits touch no count
		t0_run_bit_nxt = w_ctl ? wd[CTL_T0_RUN_BIT] : t0_run_bit_r;
		t1_run_bit_nxt = w_ctl ? wd[CTL_T1_RUN_BIT] : t1_run_bit_r;
		// RULE_01 RULE_10: overflow sets flag; set wins over software clear
		t0_overflow_flag_nxt = (t0_go & t0_step.ovf) | (w_ctl ? wd[CTL_T0_OVF_BIT] : t0_overflow_flag_r);
		t1_overflow_flag_nxt = (split0 ? th0_go & th0_sum[8] : t1_go & t1_step.ovf)
		                       | (w_ctl ? wd[CTL_T1_OVF_BIT] : t1_overflow_flag_r);
		// RULE_11: timer 1 still feeds the baud tick while timer 0 is split
		t1_tick_nxt = t1_go & t1_step.ovf;
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			t0_low_byte_r      <= RST_BYTE;
			t0_high_byte_r     <= RST_BYTE;
			t1_low_byte_r      <= RST_BYTE;
			t1_high_byte_r     <= RST_BYTE;
			t0_mode_r          <= '0;
			t1_mode_r          <= '0;
			t0_run_bit_r       <= 1'b0;
			t1_run_bit_r       <= 1'b0;
			t0_overflow_flag_r <= 1'b0;
			t1_overflow_flag_r <= 1'b0;
			t1_tick_r          <= 1'b0;
		end else begin
			t0_low_byte_r      <= t0_low_byte_nxt;
			t0_high_byte_r     <= t0_high_byte_nxt;
			t1_low_byte_r      <= t1_low_byte_nxt;
			t1_high_byte_r     <= t1_high_byte_nxt;
			t0_mode_r          <= t0_mode_nxt;
			t1_mode_r          <= t1_mode_nxt;
			t0_run_bit_r       <= t0_run_bit_nxt;
			t1_run_bit_r       <= t1_run_bit_nxt;
			t0_overflow_flag_r <= t0_overflow_flag_nxt;
			t1_overflow_flag_r <= t1_overflow_flag_nxt;
			t1_tick_r          <= t1_tick_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// timer 2
	logic [7:0]  t2_low_byte_r, t2_high_byte_r, t2_reload_low_r, t2_reload_high_r;
	logic [7:0]  t2_low_byte_nxt, t2_high_byte_nxt, t2_reload_low_nxt, t2_reload_high_nxt;
	mtc_t2ctl_t  timer2_control_reg_r, timer2_control_reg_nxt;
	logic        t2_tick_r, t2_tick_nxt;
	mtc_t2mode_t t2_mode;
	logic        baud_sel, ext_ev, t2_go, t2_roll, t2_load, t2_capture;
	logic [16:0] t2_sum;

	always_comb begin
		baud_sel = timer2_control_reg_r.rclk | timer2_control_reg_r.tx_clk_sel;
		// RULE_12: mode decode
		if (!timer2_control_reg_r.run)
			t2_mode = T2_OFF;
		else if (baud_sel)
			t2_mode = T2_BAUD;
		else if (timer2_control_reg_r.cap_sel)
			t2_mode = T2_CAPTURE;
		else
			t2_mode = T2_RELOAD;
		ext_ev  = timer2_control_reg_r.ext_en & pin_fall[PIN_T2TRIG];
		// RULE_20: count pin or core clock
		t2_go   = timer2_control_reg_r.run & (timer2_control_reg_r.ct2 ? pin_fall[PIN_T2] : 1'b1);
		t2_sum  = {1'b0, t2_high_byte_r, t2_low_byte_r} + 17'h00001;
		t2_roll = t2_go & t2_sum[16];
		// RULE_13 RULE_14 RULE_20: reload on rollover or trigger, forced in baud
		t2_load = (t2_roll & (t2_mode != T2_CAPTURE)) | (ext_ev & ~baud_sel & ~timer2_control_reg_r.cap_sel);
		// RULE_16: capture only outside baud mode
		t2_capture = ext_ev & ~baud_sel & timer2_control_reg_r.cap_sel;

		if (t2_load)
			{t2_high_byte_nxt, t2_low_byte_nxt} = {t2_reload_high_r, t2_reload_low_r};
		else if (t2_go)
			{t2_high_byte_nxt, t2_low_byte_nxt} = t2_sum[15:0];
		else
			{t2_high_byte_nxt, t2_low_byte_nxt} = {t2_high_byte_r, t2_low_byte_r};
		t2_reload_low_nxt  = t2_capture ? t2_low_byte_r : t2_reload_low_r;
		t2_reload_high_nxt = t2_capture ? t2_high_byte_r : t2_reload_high_r;
		if (w_lo2) t2_low_byte_nxt = wd;
		if (w_hi2) t2_high_byte_nxt = wd;
		if (w_rcl) t2_reload_low_nxt = wd;
		if (w_rch) t2_reload_high_nxt = wd;

		timer2_control_reg_nxt = w_ctl2 ? mtc_t2ctl_t'(wd) : timer2_control_reg_r;
		// RULE_15 RULE_17 RULE_19: overflow flag, never while a serial clock select is set
		timer2_control_reg_nxt.ovf_flag = ((t2_roll & ~baud_sel) | timer2_control_reg_nxt.ovf_flag) & ~baud_sel;
		// RULE_14 RULE_16 RULE_18 RULE_19: trigger sets flag in every mode; set wins
		timer2_control_reg_nxt.ext_flag = ext_ev | timer2_control_reg_nxt.ext_flag;
		t2_tick_nxt = t2_roll & baud_sel;
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			t2_low_byte_r        <= RST_BYTE;
			t2_high_byte_r       <= RST_BYTE;
			t2_reload_low_r      <= RST_BYTE;
			t2_reload_high_r     <= RST_BYTE;
			timer2_control_reg_r <= '0;
			t2_tick_r            <= 1'b0;
		end else begin
			t2_low_byte_r        <= t2_low_byte_nxt;
			t2_high_byte_r       <= t2_high_byte_nxt;
			t2_reload_low_r      <= t2_reload_low_nxt;
			t2_reload_high_r     <= t2_reload_high_nxt;
			timer2_control_reg_r <= timer2_control_reg_nxt;
			t2_tick_r            <= t2_tick_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data, one cycle after the read strobe
	logic [7:0] rdata_r, rdata_nxt;

	always_comb begin
		rdata_nxt = rdata_r;
		if (SFR_REQ_IN.rd) begin
			case (SFR_REQ_IN.addr)
				ADDR_CTL01: rdata_nxt = {t1_overflow_flag_r, t1_run_bit_r, t0_overflow_flag_r, t0_run_bit_r, 4'h0};
				ADDR_MOD01: rdata_nxt = {t1_mode_r, t0_mode_r};
				ADDR_LO0:   rdata_nxt = t0_low_byte_r;
				ADDR_HI0:   rdata_nxt = t0_high_byte_r;
				ADDR_LO1:   rdata_nxt = t1_low_byte_r;
				ADDR_HI1:   rdata_nxt = t1_high_byte_r;
				ADDR_CTL2:  rdata_nxt = timer2_control_reg_r;
				ADDR_RCAPL: rdata_nxt = t2_reload_low_r;
				ADDR_RCAPH: rdata_nxt = t2_reload_high_r;
				ADDR_LO2:   rdata_nxt = t2_low_byte_r;
				ADDR_HI2:   rdata_nxt = t2_high_byte_r;
				default:    rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			rdata_r <= RST_BYTE;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign SFR_RDATA_OUT        = rdata_r;
	assign T0_OVERFLOW_FLAG_OUT = t0_overflow_flag_r;
	assign T1_OVERFLOW_FLAG_OUT = t1_overflow_flag_r;
	assign T2_OVERFLOW_FLAG_OUT = timer2_control_reg_r.ovf_flag;
	assign T2_EXTERNAL_FLAG_OUT = timer2_control_reg_r.ext_flag;
	assign T1_OVF_TICK_OUT      = t1_tick_r;
	assign T2_BAUD_TICK_OUT     = t2_tick_r;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);

	logic t0_quiet;
	assign t0_quiet = !(w_lo0 || w_hi0 || w_ctl || w_mod);

	t0_13bit_wrap_a: assert property ( // RULE_01
		(t0_go && t0_mode_r.mode == MODE_13BIT && t0_high_byte_r == BYTE_ONES && t0_low_byte_r[4:0] == 5'h1F && t0_quiet)
		|=> (t0_overflow_flag_r && t0_high_byte_r == 8'h00 && t0_low_byte_r[4:0] == 5'h00))
		else $error("13-bit wrap wrong");
	t0_gate_hold_a: assert property ( // RULE_03
		(t0_run_bit_r && t0_mode_r.gate && !pin_level[PIN_IRQ0] && t0_quiet) |=> $stable(t0_low_byte_r))
		else $error("gated timer 0 advanced");
	start_keeps_cnt_a: assert property ( // RULE_04
		(w_ctl && wd[CTL_T0_RUN_BIT] && !t0_run_bit_r && !w_lo0 && !w_hi0) |=> $stable({t0_high_byte_r, t0_low_byte_r}))
		else $error("start changed count");
	t0_every_cycle_a: assert property ( // RULE_05
		(t0_mode_r == 4'h1 && t0_run_bit_r && t0_low_byte_r != BYTE_ONES && t0_quiet) ##1 t0_quiet
		|=> t0_low_byte_r == $past(t0_low_byte_r, 2) + 8'h02)
		else $error("timer 0 not counting each cycle");
	t0_reload_a: assert property ( // RULE_07
		(t0_go && t0_mode_r.mode == MODE_AUTO8 && t0_low_byte_r == BYTE_ONES && t0_quiet)
		|=> (t0_low_byte_r == t0_high_byte_r && t0_overflow_flag_r && $stable(t0_high_byte_r)))
		else $error("mode 2 reload wrong");
	t1_mode3_hold_a: assert property ( // RULE_08
		(t1_mode_r.mode == MODE_SPLIT && !w_lo1 && !w_hi1) |=> $stable({t1_high_byte_r, t1_low_byte_r}))
		else $error("timer 1 moved in mode 3");
	split_high_ovf_a: assert property ( // RULE_10
		(split0 && t1_run_bit_r && t0_high_byte_r == BYTE_ONES && t0_quiet) |=> (t1_overflow_flag_r && t0_high_byte_r == 8'h00))
		else $error("split high byte overflow wrong");
	t2_reload_a: assert property ( // RULE_13
		(t2_mode == T2_RELOAD && t2_roll && !w_lo2 && !w_hi2 && !w_ctl2)
		|=> ({t2_high_byte_r, t2_low_byte_r} == $past({t2_reload_high_r, t2_reload_low_r}) && timer2_control_reg_r.ovf_flag))
		else $error("timer 2 reload wrong");
	t2_capture_a: assert property ( // RULE_16
		(t2_capture && !w_rcl && !w_rch && !w_ctl2)
		|=> ({t2_reload_high_r, t2_reload_low_r} == $past({t2_high_byte_r, t2_low_byte_r}) && timer2_control_reg_r.ext_flag))
		else $error("timer 2 capture wrong");
	baud_no_flag_a: assert property ( // RULE_17
		baud_sel |=> !timer2_control_reg_r.ovf_flag)
		else $error("overflow flag set in baud mode");
	baud_ext_flag_a: assert property ( // RULE_18
		(ext_ev && baud_sel) |=> timer2_control_reg_r.ext_flag)
		else $error("external flag missed in baud mode");

	t0_ovf_c: cover property (t0_go && t0_step.ovf);
	t2_capture_c: cover property (t2_capture);
	t2_baud_c: cover property (t2_tick_nxt);
	split_c: cover property (split0 && th0_go && th0_sum[8]);

endmodule
`default_nettype wire

// ==== inc/mtc_pkg.sv ====
// package: register map, field positions and carrier types of the timer/counters
package mtc_pkg;

	// special function register addresses
	localparam logic [7:0] ADDR_CTL01  = 8'h88;
	localparam logic [7:0] ADDR_MOD01  = 8'h89;
	localparam logic [7:0] ADDR_LO0    = 8'h8A;
	localparam logic [7:0] ADDR_LO1    = 8'h8B;
	localparam logic [7:0] ADDR_HI0    = 8'h8C;
	localparam logic [7:0] ADDR_HI1    = 8'h8D;
	localparam logic [7:0] ADDR_CTL2   = 8'hC8;
	localparam logic [7:0] ADDR_RCAPL  = 8'hCA;
	localparam logic [7:0] ADDR_RCAPH  = 8'hCB;
	localparam logic [7:0] ADDR_LO2    = 8'hCC;
	localparam logic [7:0] ADDR_HI2    = 8'hCD;

	// field positions
	localparam int CTL_T1_OVF_BIT = 7;
	localparam int CTL_T1_RUN_BIT = 6;
	localparam int CTL_T0_OVF_BIT = 5;
	localparam int CTL_T0_RUN_BIT = 4;
	localparam int MOD_T1_LSB     = 4;
	localparam int MOD_T0_LSB     = 0;

	// reset values and count limits
	localparam logic [7:0] RST_BYTE  = 8'h00;
	localparam logic [7:0] BYTE_ONES = 8'hFF;

	// timer 0/1 modes
	localparam logic [1:0] MODE_13BIT = 2'h0;
	localparam logic [1:0] MODE_16BIT = 2'h1;
	localparam logic [1:0] MODE_AUTO8 = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;

	// pin positions in the sampled pin vector
	localparam int PIN_CNT    = 6;
	localparam int PIN_IRQ0   = 0;
	localparam int PIN_IRQ1   = 1;
	localparam int PIN_T0     = 2;
	localparam int PIN_T1     = 3;
	localparam int PIN_T2     = 4;
	localparam int PIN_T2TRIG = 5;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mtc_sfr_req_t;

	typedef struct packed {
		logic       gate;
		logic       ct;
		logic [1:0] mode;
	} mtc_timer01_mode_reg_t;

	typedef struct packed {
		logic ovf_flag;
		logic ext_flag;
		logic rclk;
		logic tx_clk_sel;
		logic ext_en;
		logic run;
		logic ct2;
		logic cap_sel;
	} mtc_t2ctl_t;

	typedef struct packed {
		logic       ovf;
		logic [7:0] hi;
		logic [7:0] lo;
	} mtc_cnt_t;

	typedef enum logic [1:0] {
		T2_OFF     = 2'h0,
		T2_RELOAD  = 2'h1,
		T2_CAPTURE = 2'h3,
		T2_BAUD    = 2'h2
	} mtc_t2mode_t;

endpackage

// ==== verification/mtc_pin_model.sv ====
// pin-side partner model: drives interrupt, count and trigger pins
`timescale 1ns/1ps
`default_nettype none
module mtc_pin_model import mtc_pkg::*; (
	// clock
	input  wire logic               clk_in,
	// pins towards the timers
	output var  logic [PIN_CNT-1:0] pins_out
);
	// idle high at reset
	// pins rest high so that reset release never shows a falling edge
	initial pins_out = '1;

	task automatic set_pin(input int idx, input logic lvl);
		@(negedge clk_in);
		pins_out[idx] = lvl;
	endtask

	// whole edge pulses
	// three cycles low then two high: wider than the synchroniser needs
	task automatic pulse(input int idx);
		set_pin(idx, 1'b0);
		repeat (2) @(negedge clk_in);
		set_pin(idx, 1'b1);
		repeat (2) @(negedge clk_in);
	endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking testbench for the timer/counters
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb import mtc_pkg::*;;
	logic         clk;
	logic         rst;
	mtc_sfr_req_t req;
	logic [7:0]   rdata;
	logic [5:0]   pins;
	logic [3:0]   flags;
	logic         t1_tick;
	logic         baud_tick;
	logic [7:0]   v;
	int           mismatches;
	int           compares;

	mtc_timer_counters i_mtc_timer_counters (
		.CLK_IN(clk), .RESET_IN(rst), .SFR_REQ_IN(req), .SFR_RDATA_OUT(rdata),
		.EXT_IRQ0_PIN_IN(pins[PIN_IRQ0]), .EXT_IRQ1_PIN_IN(pins[PIN_IRQ1]),
		.T0_COUNT_PIN_IN(pins[PIN_T0]), .T1_COUNT_PIN_IN(pins[PIN_T1]),
		.T2_COUNT_PIN_IN(pins[PIN_T2]), .T2_TRIGGER_INPUT_IN(pins[PIN_T2TRIG]),
		.T0_OVERFLOW_FLAG_OUT(flags[0]), .T1_OVERFLOW_FLAG_OUT(flags[1]),
		.T2_OVERFLOW_FLAG_OUT(flags[2]), .T2_EXTERNAL_FLAG_OUT(flags[3]),
		.T1_OVF_TICK_OUT(t1_tick), .T2_BAUD_TICK_OUT(baud_tick)
	);

	mtc_pin_model i_mtc_pin_model (
		.clk_in  (clk),
		.pins_out(pins)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		req = '0;
	endtask

	// read data is registered at the edge that takes rd
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk);
		req = '0;
		d = rdata;
	endtask

	// short bounds: a prescaler or a cleared count would miss them
	task automatic wait_flag(input int idx, input int bound);
		int n = 0;
		while (flags[idx] !== 1'b1 && n < bound) begin
			@(negedge clk);
			n++;
		end
		if (flags[idx] !== 1'b1) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, flags[idx], 1'b1);
			wrap_up();
		end
	endtask

	task automatic load(input logic [7:0] al, input logic [7:0] dl, input logic [7:0] ah, input logic [7:0] dh);
		wr(al, dl);
		wr(ah, dh);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [7:0] addrs [11] = '{ADDR_CTL01, ADDR_MOD01, ADDR_LO0, ADDR_LO1, ADDR_HI0, ADDR_HI1,
			ADDR_CTL2, ADDR_RCAPL, ADDR_RCAPH, ADDR_LO2, 8'hC0};
		foreach (addrs[i]) begin
			rd(addrs[i], v);
			`CHK(v, RST_BYTE)
		end
		`CHK(flags, 4'h0)
		$display("test reset done");
	endtask

	task automatic t_timer0();
		wr(ADDR_MOD01, 8'h01);
		load(ADDR_LO0, 8'hFE, ADDR_HI0, 8'hFF);
		wr(ADDR_CTL01, 8'h10);
		wait_flag(0, 8);
		wr(ADDR_CTL01, 8'h00);
		rd(ADDR_HI0, v);
		`CHK(v, 8'h00)
		`CHK(flags[0], 1'b0)
		wr(ADDR_MOD01, 8'h00);
		load(ADDR_LO0, 8'hFE, ADDR_HI0, 8'hFF);
		wr(ADDR_CTL01, 8'h10);
		wait_flag(0, 8);
		wr(ADDR_CTL01, 8'h00);
		rd(ADDR_HI0, v);
		`CHK(v, 8'h00)
		$display("test timer0 modes done");
	endtask

	task automatic t_auto8();
		wr(ADDR_MOD01, 8'h20);
		load(ADDR_LO1, 8'hFE, ADDR_HI1, 8'hF0);
		wr(ADDR_CTL01, 8'h40);
		wait_flag(1, 8);
		wr(ADDR_CTL01, 8'h00);
		rd(ADDR_HI1, v);
		`CHK(v, 8'hF0)
		rd(ADDR_LO1, v);
		`CHK(v[7:4], 4'hF)
		$display("test autoreload8 done");
	endtask

	task automatic t_gate();
		i_mtc_pin_model.set_pin(PIN_IRQ0, 1'b0);
		wr(ADDR_MOD01, 8'h09);
		load(ADDR_LO0, 8'h00, ADDR_HI0, 8'h00);
		idle(4);
		wr(ADDR_CTL01, 8'h10);
		idle(10);
		wr(ADDR_CTL01, 8'h00);
		rd(ADDR_LO0, v);
		`CHK(v, 8'h00)
		i_mtc_pin_model.set_pin(PIN_IRQ0, 1'b1);
		idle(4);
		wr(ADDR_CTL01, 8'h10);
		idle(10);
		wr(ADDR_CTL01, 8'h00);
		rd(ADDR_LO0, v);
		`CHK(v !== 8'h00, 1'b1)
		$display("test gate done");
	endtask

	task automatic t_split();
		logic t1_seen = 1'b0;
		wr(ADDR_MOD01, 8'h03);
		load(ADDR_LO0, 8'h77, ADDR_HI0, 8'hFE);
		wr(ADDR_CTL01, 8'h40);
		wait_flag(1, 8);
		wr(ADDR_CTL01, 8'h00);
		rd(ADDR_LO0, v);
		`CHK(v, 8'h77)
		`CHK(flags[0], 1'b0)
		wr(ADDR_LO0, 8'hFE);
		wr(ADDR_CTL01, 8'h10);
		wait_flag(0, 8);
		wr(ADDR_MOD01, 8'h31);
		wr(ADDR_LO1, 8'h33);
		wr(ADDR_CTL01, 8'h40);
		idle(8);
		wr(ADDR_CTL01, 8'h00);
		rd(ADDR_LO1, v);
		`CHK(v, 8'h33)
		// timer 1 out of mode 3 runs on, ticking without its flag
		wr(ADDR_MOD01, 8'h23);
		load(ADDR_LO1, 8'hFE, ADDR_HI1, 8'hF0);
		wr(ADDR_CTL01, 8'h40);
		repeat (8) begin
			@(negedge clk);
			t1_seen |= (t1_tick === 1'b1);
		end
		`CHK(flags[1], 1'b0)
		wr(ADDR_CTL01, 8'h00);
		`CHK(t1_seen, 1'b1)
		$display("test split done");
	endtask

	task automatic t_timer2();
		load(ADDR_RCAPL, 8'h34, ADDR_RCAPH, 8'h12);
		load(ADDR_LO2, 8'hFE, ADDR_HI2, 8'hFF);
		wr(ADDR_CTL2, 8'h04);
		wait_flag(2, 8);
		wr(ADDR_CTL2, 8'h00);
		rd(ADDR_HI2, v);
		`CHK(v, 8'h12)
		`CHK(flags[2], 1'b0)
		load(ADDR_LO2, 8'h00, ADDR_HI2, 8'h00);
		wr(ADDR_CTL2, 8'h08);
		i_mtc_pin_model.pulse(PIN_T2TRIG);
		wait_flag(3, 8);
		rd(ADDR_LO2, v);
		`CHK(v, 8'h34)
		load(ADDR_LO2, 8'h5A, ADDR_HI2, 8'hA5);
		wr(ADDR_CTL2, 8'h09);
		i_mtc_pin_model.pulse(PIN_T2TRIG);
		wait_flag(3, 8);
		rd(ADDR_RCAPL, v);
		`CHK(v, 8'h5A)
		rd(ADDR_RCAPH, v);
		`CHK(v, 8'hA5)
		load(ADDR_LO2, 8'hFE, ADDR_HI2, 8'hFF);
		wr(ADDR_CTL2, 8'h05);
		wait_flag(2, 8);
		wr(ADDR_CTL2, 8'h00);
		$display("test timer2 done");
	endtask

	task automatic t_baud();
		logic tick_seen = 1'b0;
		logic ovf_seen = 1'b0;
		load(ADDR_LO2, 8'hFE, ADDR_HI2, 8'hFF);
		wr(ADDR_CTL2, 8'h2C);
		repeat (20) begin
			@(negedge clk);
			tick_seen |= (baud_tick === 1'b1);
			ovf_seen |= (flags[2] === 1'b1);
		end
		`CHK(tick_seen, 1'b1)
		`CHK(ovf_seen, 1'b0)
		i_mtc_pin_model.pulse(PIN_T2TRIG);
		wait_flag(3, 8);
		wr(ADDR_CTL2, 8'h00);
		load(ADDR_LO2, 8'h00, ADDR_HI2, 8'h00);
		wr(ADDR_CTL2, 8'h06);
		repeat (3) i_mtc_pin_model.pulse(PIN_T2);
		idle(6);
		wr(ADDR_CTL2, 8'h00);
		rd(ADDR_LO2, v);
		`CHK(v, 8'h03)
		$display("test baud and counter done");
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		mismatches = 0;
		compares = 0;
		req = '0;
		rst = 1'b1;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		idle(4);
		t_reset();
		t_timer0();
		t_auto8();
		t_gate();
		t_split();
		t_timer2();
		t_baud();
		wrap_up();
	end
endmodule
`undef CHK
`default_nettype wire
